/* File: core/ssl_start_stop.v */
// start/stop and fault input logic with apb register slave
// assumes one 20 MHz clock and an apb master on the same clock
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ssl_defs.vh"

module ssl_start_stop #(
    parameter INPUTS = 6
) (
    input  wire              clock,
    input  wire              reset,
    input  wire              clock_enable,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire [INPUTS-1:0] digital_input,
    input  wire              fault_report,
    output reg               run,
    output reg               reverse,
    output reg               ext_fault,
    output wire              irq
);

    reg  [2:0] start_stop_scheme_select;
    reg  [2:0] forward_start_input_select;
    reg  [2:0] stop_reverse_input_select;
    reg  [2:0] direction_flip_input_select;
    reg  [2:0] ext_fault_no_input_select;
    reg        auto_restart_setting;
    reg  [`SSL_IRQ_BITS-1:0] irq_status;
    reg  [`SSL_IRQ_BITS-1:0] irq_mask;
    reg        drive_fault;
    reg        prev_fault_report;
    reg        next_run;
    reg        next_reverse;
    reg        next_fault;
    reg        start_event;
    reg        stop_event;
    reg        restart_event;

    wire [INPUTS-1:0] in_level;
    wire [INPUTS-1:0] in_rise;
    wire [3:0]        fn_level;
    wire [3:0]        fn_rise;
    wire [2:0]        fn_select [0:3];
    wire              wr_en;
    wire              rd_en;
    wire              fault_ack;
    wire              fault_clear;
    wire              addr_ok;
    wire [`SSL_IRQ_BITS-1:0] irq_events;

    // ***********************
    // input synchroniser
    // ***********************
    ssl_input_sync #(
        .WIDTH(INPUTS)
    ) u_sync (
        .clock  (clock),
        .reset  (reset),
        .enable (clock_enable),
        .pins   (digital_input),
        .level  (in_level),
        .rise   (in_rise)
    );

    // ***********************
    // terminal assignment decode
    // ***********************
    assign fn_select[0] = forward_start_input_select;
    assign fn_select[1] = stop_reverse_input_select;
    assign fn_select[2] = direction_flip_input_select;
    assign fn_select[3] = ext_fault_no_input_select;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_route
            // 0 disables, n routes input n
            assign fn_level[g] = (fn_select[g] != 3'h0) && (fn_select[g] <= INPUTS) &&
                                 in_level[fn_select[g] - 3'h1];
            assign fn_rise[g]  = (fn_select[g] != 3'h0) && (fn_select[g] <= INPUTS) &&
                                 in_rise[fn_select[g] - 3'h1];
        end
    endgenerate

    // ***********************
    // apb slave
    // ***********************
    assign pready  = 1'b1;
    assign addr_ok = (paddr == `SSL_ADDR_SCHEME) || (paddr == `SSL_ADDR_FWD_SEL) ||
                     (paddr == `SSL_ADDR_STOP_SEL) || (paddr == `SSL_ADDR_FLIP_SEL) ||
                     (paddr == `SSL_ADDR_FAULT_SEL) || (paddr == `SSL_ADDR_CONTROL) ||
                     (paddr == `SSL_ADDR_STATUS) || (paddr == `SSL_ADDR_IRQ_STATUS) ||
                     (paddr == `SSL_ADDR_IRQ_MASK);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok && clock_enable;
    assign rd_en   = psel && !penable && !pwrite;
    assign fault_ack = wr_en && (paddr == `SSL_ADDR_CONTROL) && pwdata[`SSL_CTL_FAULT_ACK];

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            start_stop_scheme_select    <= `SSL_RST_SCHEME;
            forward_start_input_select  <= `SSL_RST_FWD_SEL;
            stop_reverse_input_select   <= `SSL_RST_STOP_SEL;
            direction_flip_input_select <= `SSL_RST_FLIP_SEL;
            ext_fault_no_input_select   <= `SSL_RST_FAULT_SEL;
            auto_restart_setting        <= 1'b0;
            irq_mask                    <= {`SSL_IRQ_BITS{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `SSL_ADDR_SCHEME: begin
                    start_stop_scheme_select <= pwdata[2:0];
                end
                `SSL_ADDR_FWD_SEL: begin
                    forward_start_input_select <= pwdata[2:0];
                end
                `SSL_ADDR_STOP_SEL: begin
                    stop_reverse_input_select <= pwdata[2:0];
                end
                `SSL_ADDR_FLIP_SEL: begin
                    direction_flip_input_select <= pwdata[2:0];
                end
                `SSL_ADDR_FAULT_SEL: begin
                    ext_fault_no_input_select <= pwdata[2:0];
                end
                `SSL_ADDR_CONTROL: begin
                    auto_restart_setting <= pwdata[`SSL_CTL_AUTO_RESTART];
                end
                `SSL_ADDR_IRQ_MASK: begin
                    irq_mask <= pwdata[`SSL_IRQ_BITS-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // read data registered in setup, stands through access
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (clock_enable && rd_en) begin
            case (paddr)
                `SSL_ADDR_SCHEME:     prdata <= {29'h0, start_stop_scheme_select};
                `SSL_ADDR_FWD_SEL:    prdata <= {29'h0, forward_start_input_select};
                `SSL_ADDR_STOP_SEL:   prdata <= {29'h0, stop_reverse_input_select};
                `SSL_ADDR_FLIP_SEL:   prdata <= {29'h0, direction_flip_input_select};
                `SSL_ADDR_FAULT_SEL:  prdata <= {29'h0, ext_fault_no_input_select};
                `SSL_ADDR_CONTROL:    prdata <= {31'h0, auto_restart_setting};
                `SSL_ADDR_STATUS:     prdata <= {29'h0, drive_fault, reverse, run};
                `SSL_ADDR_IRQ_STATUS: prdata <= {28'h0, irq_status};
                `SSL_ADDR_IRQ_MASK:   prdata <= {28'h0, irq_mask};
                default:              prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ***********************
    // start/stop schemes
    // ***********************
    always @* begin
        next_run      = run;
        next_reverse  = reverse;
        next_fault    = drive_fault;
        start_event   = 1'b0;
        stop_event    = 1'b0;
        restart_event = 1'b0;
        case (start_stop_scheme_select)
            `SSL_SCHEME_EXCL, `SSL_SCHEME_RESTART_AFTER_ERROR: begin
                // interlocked: both or none held stops
                if (fn_level[0] ^ fn_level[1]) begin
                    if (!run && !drive_fault && (fn_rise[0] || fn_rise[1])) begin
                        next_run     = 1'b1;
                        next_reverse = fn_level[1] ^ fn_level[2];
                        start_event  = 1'b1;
                    end else if (run) begin
                        next_reverse = fn_level[1] ^ fn_level[2];
                    end
                end else begin
                    next_run   = 1'b0;
                    stop_event = run;
                end
            end
            `SSL_SCHEME_DIR: begin
                next_reverse = fn_level[1] ^ fn_level[2];
                if (!fn_level[0]) begin
                    next_run   = 1'b0;
                    stop_event = run;
                end else if (!run && !drive_fault && fn_rise[0]) begin
                    next_run    = 1'b1;
                    start_event = 1'b1;
                end
            end
            `SSL_SCHEME_PULSE: begin
                next_reverse = fn_level[2];
                if (fn_rise[1]) begin
                    next_run   = 1'b0;
                    stop_event = run;
                end else if (fn_rise[0] && !run && !drive_fault) begin
                    next_run    = 1'b1;
                    start_event = 1'b1;
                end
            end
            default: begin
                next_run   = 1'b0;
                stop_event = run;
            end
        endcase
        // fault: stop, then optional restart on held level
        if (fn_rise[3] || (fault_report && !prev_fault_report)) begin
            next_fault = 1'b1;
            next_run   = 1'b0;
            stop_event = run;
            start_event = 1'b0;
        end else if (drive_fault) begin
            next_run = 1'b0;
            if ((start_stop_scheme_select == `SSL_SCHEME_RESTART_AFTER_ERROR) && auto_restart_setting &&
                !fn_level[3] && !fault_report && (fn_level[0] ^ fn_level[1])) begin
                next_fault    = 1'b0;
                next_run      = 1'b1;
                next_reverse  = fn_level[1] ^ fn_level[2];
                restart_event = 1'b1;
            end else if (fault_clear) begin
                next_fault = 1'b0;
            end
        end
    end

    assign fault_clear = fault_ack && !fn_level[3] && !fault_report;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            run               <= 1'b0;
            reverse           <= 1'b0;
            drive_fault       <= 1'b0;
            ext_fault         <= 1'b0;
            prev_fault_report <= 1'b0;
        end else if (clock_enable) begin
            run               <= next_run;
            reverse           <= next_reverse;
            drive_fault       <= next_fault;
            prev_fault_report <= fault_report;
            if (fn_rise[3]) begin
                ext_fault <= 1'b1;
            end else if (!next_fault) begin
                ext_fault <= 1'b0;
            end
        end
    end

    // ***********************
    // interrupts
    // ***********************
    assign irq_events = {restart_event, next_fault & ~drive_fault, stop_event, start_event};

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_status <= {`SSL_IRQ_BITS{1'b0}};
        end else if (clock_enable) begin
            // set wins over write-one-clear
            if (wr_en && (paddr == `SSL_ADDR_IRQ_STATUS)) begin
                irq_status <= (irq_status & ~pwdata[`SSL_IRQ_BITS-1:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

endmodule // ssl_start_stop

`default_nettype wire

/* File: core/ssl_defs.vh */
// constants for the start/stop input logic
// assumes inclusion by the block's design files only
//
// Overview of operation
// - scheme 3: forward input runs clockwise, reverse anticlockwise, exclusive.
// - scheme 2: start pulse starts drive, stop pulse stops it.
// - scheme 0 behaves as scheme 3 plus restart after fault.
// - automatic restart only when auto restart setting equals one.
// - restart after fault resumes on held level, no new edge needed.
// - scheme 1: first input is start, second selects reverse direction.
// - assignment 0 disables, 1 to 6 route inputs one to six.
// - stop, reversal and fault functions have own assignment, same decoding.
// - active reversal input inverts commanded rotation: forward becomes reverse, reverse becomes forward.
// - normally open fault input going active raises external fault.
// - functions activate on rising edge of terminal level; here stops in schemes 0, 1 and 3 and the direction follow levels.
`ifndef SSL_DEFS_VH
`define SSL_DEFS_VH

// ***********************
// register byte addresses
// ***********************
`define SSL_ADDR_SCHEME      8'h00
`define SSL_ADDR_FWD_SEL     8'h04
`define SSL_ADDR_STOP_SEL    8'h08
`define SSL_ADDR_FLIP_SEL    8'h0c
`define SSL_ADDR_FAULT_SEL   8'h10
`define SSL_ADDR_CONTROL     8'h14
`define SSL_ADDR_STATUS      8'h18
`define SSL_ADDR_IRQ_STATUS  8'h1c
`define SSL_ADDR_IRQ_MASK    8'h20

// ***********************
// reset values
// ***********************
`define SSL_RST_SCHEME       3'h3
`define SSL_RST_FWD_SEL      3'h1
`define SSL_RST_STOP_SEL     3'h2
`define SSL_RST_FLIP_SEL     3'h0
`define SSL_RST_FAULT_SEL    3'h0

// ***********************
// scheme codes
// ***********************
`define SSL_SCHEME_RESTART_AFTER_ERROR      3'h0
`define SSL_SCHEME_DIR       3'h1
`define SSL_SCHEME_PULSE     3'h2
`define SSL_SCHEME_EXCL      3'h3

// ***********************
// field positions
// ***********************
`define SSL_CTL_AUTO_RESTART 0
`define SSL_CTL_FAULT_ACK    1
`define SSL_ST_RUN           0
`define SSL_ST_REVERSE       1
`define SSL_ST_FAULT         2
`define SSL_IRQ_START        0
`define SSL_IRQ_STOP         1
`define SSL_IRQ_FAULT        2
`define SSL_IRQ_RESTART      3
`define SSL_IRQ_BITS         4

`endif

/* File: core/ssl_input_sync.v */
// three-stage synchroniser with edge detect for the digital inputs
// assumes one clock; inputs may be asynchronous to it
`timescale 1ns/10ps
`default_nettype none

module ssl_input_sync #(
    parameter WIDTH = 6
) (
    input  wire             clock,
    input  wire             reset,
    input  wire             enable,
    input  wire [WIDTH-1:0] pins,
    output reg  [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise
);

    reg [WIDTH-1:0] first_stage;
    reg [WIDTH-1:0] second_stage;
    reg [WIDTH-1:0] prev_level;

    // ***********************
    // sync and previous sample
    // ***********************
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            first_stage  <= {WIDTH{1'b0}};
            second_stage <= {WIDTH{1'b0}};
            level        <= {WIDTH{1'b0}};
            prev_level   <= {WIDTH{1'b0}};
        end else if (enable) begin
            first_stage  <= pins;
            second_stage <= first_stage;
            level        <= second_stage;
            prev_level   <= level;
        end
    end

    // edge aligned with the level the decoder sees
    assign rise = level & ~prev_level;

endmodule // ssl_input_sync

`default_nettype wire

/* File: tb/ssl_asserts.sv */
// checker for the start/stop input logic
// assumes a bind onto ssl_start_stop, inputs active high
`timescale 1ns/10ps
`default_nettype none
module ssl_asserts #(parameter INPUTS = 6) (
    input wire logic              clock,
    input wire logic              reset,
    input wire logic              clock_enable,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [INPUTS-1:0] digital_input,
    input wire logic              fault_report,
    input wire logic              run,
    input wire logic              reverse,
    input wire logic              ext_fault
);
    logic [2:0] cfg [0:5];
    logic [3:0] frc;
    function automatic logic pin(input logic [2:0] s, input logic [INPUTS-1:0] d);
        return s != 3'h0 && s != 3'h7 && d[s - 3'h1];
    endfunction
    wire wr = psel && penable && pwrite && clock_enable;
    wire ack = wr && paddr == 8'h14 && pwdata[1];
    wire f = pin(cfg[1], digital_input);
    wire r = pin(cfg[2], digital_input);
    wire v = pin(cfg[3], digital_input);
    wire x = pin(cfg[4], digital_input);
    wire xs = cfg[0] == 3'h0 || cfg[0] == 3'h3;
    wire ds = xs || cfg[0] == 3'h1;
    // ********************
    // register mirror
    // ********************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cfg[0] <= 3'h3;
            cfg[1] <= 3'h1;
            cfg[2] <= 3'h2;
            cfg[3] <= 3'h0;
            cfg[4] <= 3'h0;
            cfg[5] <= 3'h0;
            frc <= 4'hf;
        end else begin
            if (wr && paddr <= 8'h14 && paddr[1:0] == 2'h0)
                cfg[paddr[4:2]] <= pwdata[2:0];
            if (fault_report)
                frc <= 4'h0;
            else if (frc != 4'hf)
                frc <= frc + 4'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_reverse_follows: assert property (
        run && ds |-> reverse == ($past(r, 4) ^ $past(v, 4))) else $error("reverse wrong");
    a_both_held_stop: assert property (
        xs && $past(f && r, 4) |-> !run) else $error("run with both held");
    a_dir_needs_fwd: assert property (
        cfg[0] == 3'h1 && !$past(f, 4) |-> !run) else $error("run without start");
    a_stop_pulse_wins: assert property (
        cfg[0] == 3'h2 && $past(r, 4) && !$past(r, 5) |-> !run) else $error("stop pulse lost");
    a_start_needs_edge: assert property (
        $rose(run) && !$past(ext_fault) && !$past(ext_fault, 2) && !(cfg[0] == 3'h0 && cfg[5][0])
        |-> ($past(f, 4) && !$past(f, 5)) || (xs && $past(r, 4) && !$past(r, 5)))
        else $error("start without edge");
    a_fault_cause: assert property (
        $rose(ext_fault) && frc > 4'h8 |-> $past(x, 4) && !$past(x, 5)) else $error("fault without cause");
    a_fault_blocks_run: assert property (
        ext_fault && $past(ext_fault) |-> !run) else $error("run during fault");
    a_restart_gate: assert property (
        $fell(ext_fault) && !$past(ack) |-> (cfg[0] == 3'h0 && cfg[5][0]) ##[0:1] run)
        else $error("restart wrong");
    c_reverse_run: cover property ($rose(run) && reverse);
    c_fault_raise: cover property ($rose(ext_fault));
    c_auto_restart: cover property ($fell(ext_fault) && !$past(ack));
endmodule // ssl_asserts
bind ssl_start_stop ssl_asserts #(.INPUTS(INPUTS)) u_ssl_asserts (
    .clock(clock), .reset(reset), .clock_enable(clock_enable), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .digital_input(digital_input),
    .fault_report(fault_report), .run(run), .reverse(reverse), .ext_fault(ext_fault)
);
`default_nettype wire

/* File: tb/ssl_switches.sv */
// switch model driving the digital input terminals
// assumes source-type wiring with pull-downs, active high
`timescale 1ns/10ps
`default_nettype none
module ssl_switches #(parameter INPUTS = 6) (
    input  wire logic              clock,
    output var  logic [INPUTS-1:0] digital_input
);
    initial digital_input = '0;
    task automatic hold(input logic [INPUTS-1:0] s);
        @(posedge clock);
        digital_input <= s;
    endtask
    task automatic pulse(input logic [INPUTS-1:0] s);
        hold(s);
        repeat (3) @(posedge clock);
        digital_input <= '0;
    endtask
endmodule // ssl_switches
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the start/stop input logic
// assumes design, switch model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clock, reset, psel, penable, pwrite, fault_report, err, ce;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, run, reverse, ext_fault, irq;
    wire  [5:0]  din;
    int          bad_count, comparisons, cyc, m, pf, pr, nf, nr;
    int          q[$];
    int          rv[6] = '{3, 1, 2, 0, 0, 0};
    ssl_start_stop u_ssl_start_stop (
        .clock(clock), .reset(reset), .clock_enable(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .digital_input(din), .fault_report(fault_report), .run(run), .reverse(reverse),
        .ext_fault(ext_fault), .irq(irq)
    );
    ssl_switches u_ssl_switches (.clock(clock), .digital_input(din));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic conclude;
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic look(input int er, input int ev);
        repeat (6) @(posedge clock);
        chk(run, er);
        if (er == 1 && ev < 2)
            chk(reverse, ev);
    endtask
    // ********************
    // main sequence
    // ********************
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        fault_report = 1'b0;
        ce = 1'b1;
        void'($urandom(32'h6d68));
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rdata, rv[i]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(rdata, 32'h0);
        apb(1'b1, 8'h20, 32'hf);
        repeat (12) q.push_back($urandom % 4);
        foreach (q[i]) begin
            nf = q[i] % 2;
            nr = q[i] / 2;
            if (nf == nr)
                m = 0;
            else if ((nf && !pf) || (nr && !pr))
                m = 1;
            pf = nf;
            pr = nr;
            u_ssl_switches.hold(6'(q[i]));
            look(m, nr);
        end
        for (int i = 1; i < 7; i++) begin
            u_ssl_switches.hold(6'h0);
            apb(1'b1, 8'h04, i);
            apb(1'b1, 8'h08, i % 6 + 1);
            u_ssl_switches.hold(6'(1 << (i - 1)));
            look(1, 0);
            u_ssl_switches.hold(6'(1 << (i % 6)));
            look(1, 1);
            u_ssl_switches.hold(~(6'(1 << (i - 1)) | 6'(1 << (i % 6))));
            look(0, 0);
        end
        u_ssl_switches.hold(6'h0);
        apb(1'b1, 8'h04, 32'h0);
        u_ssl_switches.hold(6'h3f);
        look(1, 1);
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h08, 32'h2);
        u_ssl_switches.hold(6'h0);
        apb(1'b1, 8'h00, 32'h1);
        u_ssl_switches.hold(6'h1);
        look(1, 0);
        u_ssl_switches.hold(6'h3);
        look(1, 1);
        u_ssl_switches.hold(6'h2);
        look(0, 0);
        u_ssl_switches.hold(6'h0);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h0c, 32'h3);
        u_ssl_switches.hold(6'h1);
        look(1, 0);
        u_ssl_switches.hold(6'h5);
        look(1, 1);
        u_ssl_switches.hold(6'h0);
        apb(1'b1, 8'h0c, 32'h0);
        apb(1'b1, 8'h00, 32'h2);
        u_ssl_switches.pulse(6'h1);
        look(1, 2);
        u_ssl_switches.pulse(6'h2);
        look(0, 2);
        u_ssl_switches.pulse(6'h3);
        look(0, 2);
        @(posedge clock);
        ce <= 1'b0;
        u_ssl_switches.pulse(6'h1);
        apb(1'b1, 8'h00, 32'h3);
        ce <= 1'b1;
        look(0, 2);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdata, 32'h2);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h10, 32'h4);
        apb(1'b1, 8'h1c, 32'hf);
        u_ssl_switches.hold(6'h1);
        look(1, 0);
        chk(irq, 1'b1);
        u_ssl_switches.hold(6'h9);
        look(0, 0);
        apb(1'b0, 8'h18, 32'h0);
        chk(rdata, 32'h4);
        u_ssl_switches.hold(6'h1);
        look(0, 0);
        apb(1'b1, 8'h14, 32'h2);
        look(0, 0);
        chk(ext_fault, 1'b0);
        apb(1'b1, 8'h20, 32'h0);
        @(posedge clock);
        chk(irq, 1'b0);
        apb(1'b1, 8'h00, 32'h0);
        u_ssl_switches.hold(6'h2);
        look(1, 1);
        @(posedge clock);
        fault_report <= 1'b1;
        repeat (3) @(posedge clock);
        fault_report <= 1'b0;
        look(0, 2);
        apb(1'b0, 8'h18, 32'h0);
        chk(rdata[2], 1'b1);
        apb(1'b1, 8'h14, 32'h1);
        look(1, 1);
        apb(1'b0, 8'h18, 32'h0);
        chk(rdata, 32'h3);
        u_ssl_switches.hold(6'ha);
        look(0, 2);
        chk(ext_fault, 1'b1);
        u_ssl_switches.hold(6'h2);
        look(1, 1);
        chk(ext_fault, 1'b0);
        apb(1'b0, 8'h1c, 32'h0);
        chk(rdata[3], 1'b1);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
